//--- hw/nor_host_consts.svh
`ifndef NOR_HOST_CONSTS_SVH
`define NOR_HOST_CONSTS_SVH

// command addresses and codes
`define ADR_UNLOCK1 11'h555
`define ADR_UNLOCK2 11'h2AA
`define ADR_ANY 11'h000
`define D_UNLOCK1 16'h00AA
`define D_UNLOCK2 16'h0055
`define D_RESET 16'h00F0
`define D_CFI 16'h0098
`define D_ASEL 16'h0090
`define D_BYPASS 16'h0020
`define D_BYPASS_RST1 16'h0090
`define D_BYPASS_RST2 16'h0000
`define D_ERASE_SETUP 16'h0080
`define D_ERASE_CONFIRM 16'h0030
`define D_SUSPEND 16'h00B0
`define D_RESUME 16'h0030
`define D_BLANK 16'h0033
`define D_BUF_LOAD 16'h0025
`define D_BUF_CONFIRM 16'h0029

// status and page layout
`define ABORT_BIT 1
`define PAGE_BITS 9

// timing, in ns at the clock period below
`define CLK_PERIOD_NS 10
`define T_SETUP_NS 20
`define T_WP_NS 50
`define T_ACC_NS 120
`define T_HOLD_NS 30
`define T_HWRST_NS 10000
`define NS_TO_CYC(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_STAGES 2

`endif

//--- hw/nor_host_pkg.sv
package nor_host_pkg;

    typedef enum logic [3:0] {
        OP_READ = 4'h0,
        OP_RESET = 4'h1,
        OP_RESET3 = 4'h2,
        OP_CFI_ENTER = 4'h3,
        OP_ASEL_ENTER = 4'h4,
        OP_BYPASS_ENTER = 4'h5,
        OP_BYPASS_EXIT = 4'h6,
        OP_BLOCK_ERASE = 4'h7,
        OP_SUSPEND = 4'h8,
        OP_RESUME = 4'h9,
        OP_BLANK_CHECK = 4'hA,
        OP_BUF_PROGRAM = 4'hB,
        OP_HW_RESET = 4'hC
    } op_e;

    typedef enum logic [1:0] {
        MODE_READ = 2'h0,
        MODE_ASEL = 2'h1,
        MODE_CFI = 2'h2
    } mode_e;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'h0,
        BUS_SETUP = 2'h1,
        BUS_PULSE = 2'h2,
        BUS_HOLD = 2'h3
    } bus_st_e;

endpackage

//--- hw/nor_bus_cycle.sv
`include "nor_host_consts.svh"

module nor_bus_cycle import nor_host_pkg::*; #(
    parameter int ADDR_W = 26
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_start,
    input wire logic i_read,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [15:0] i_data,
    input wire logic [15:0] i_dq,
    output logic o_done,
    output logic [15:0] o_rdata,
    output logic o_ce_n,
    output logic o_oe_n,
    output logic o_we_n,
    output logic [ADDR_W-1:0] o_addr,
    output logic [15:0] o_dq,
    output logic o_dq_oe
);

    localparam logic [7:0] SETUP_CYC = 8'(`NS_TO_CYC(`T_SETUP_NS));
    localparam logic [7:0] WP_CYC = 8'(`NS_TO_CYC(`T_WP_NS));
    // read pulse is stretched by the synchroniser depth so dq2 holds settled data
    localparam logic [7:0] READ_CYC = 8'(`NS_TO_CYC(`T_ACC_NS) + `SYNC_STAGES);
    localparam logic [7:0] HOLD_CYC = 8'(`NS_TO_CYC(`T_HOLD_NS));

    typedef struct packed {
        bus_st_e st;
        logic [7:0] cnt;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [15:0] data;
        logic dq_oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [15:0] dq1;
        logic [15:0] dq2;
        logic done;
        logic [15:0] rdata;
    } bus_s;

    bus_s r, next_r;

    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        next_r.dq1 = i_dq;
        next_r.dq2 = r.dq1;
        unique case (r.st)
            BUS_IDLE: begin
                if (i_start) begin
                    next_r.st = BUS_SETUP;
                    next_r.cnt = SETUP_CYC;
                    next_r.rd = i_read;
                    next_r.addr = i_addr;
                    next_r.data = i_data;
                    next_r.ce_n = 1'b0;
                    next_r.dq_oe = !i_read;
                end
            end
            BUS_SETUP: begin
                if (r.cnt == 8'h01) begin
                    next_r.st = BUS_PULSE;
                    next_r.cnt = r.rd ? READ_CYC : WP_CYC;
                    next_r.oe_n = !r.rd;
                    next_r.we_n = r.rd;
                end else begin
                    next_r.cnt = r.cnt - 8'h01;
                end
            end
            BUS_PULSE: begin
                if (r.cnt == 8'h01) begin
                    next_r.st = BUS_HOLD;
                    next_r.cnt = HOLD_CYC;
                    next_r.oe_n = 1'b1;
                    next_r.we_n = 1'b1;
                    if (r.rd) begin
                        next_r.rdata = r.dq2;
                    end
                end else begin
                    next_r.cnt = r.cnt - 8'h01;
                end
            end
            BUS_HOLD: begin
                // write data stays driven past the rising strobe edge
                if (r.cnt == 8'h01) begin
                    next_r.st = BUS_IDLE;
                    next_r.ce_n = 1'b1;
                    next_r.dq_oe = 1'b0;
                    next_r.done = 1'b1;
                end else begin
                    next_r.cnt = r.cnt - 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            r <= '0;
            r.st <= BUS_IDLE;
            r.ce_n <= 1'b1;
            r.oe_n <= 1'b1;
            r.we_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign o_done = r.done;
    assign o_rdata = r.rdata;
    assign o_ce_n = r.ce_n;
    assign o_oe_n = r.oe_n;
    assign o_we_n = r.we_n;
    assign o_addr = r.addr;
    assign o_dq = r.data;
    assign o_dq_oe = r.dq_oe;

endmodule // nor_bus_cycle

//--- hw/nor_flash_host.sv
`include "nor_host_consts.svh"

// How it works
// - block erase: unlocks, 80, unlocks, 30 at block
// - bypass erase: 80 at 555 then 30 at block
// - suspend B0, resume 30, blank check 33@555
// - after abort error use three-write reset only
// - program loads N+1 words, at most 512
// - confirm uses same block address as load
// - load keeps upper address, word on A[8:0]
// - recover by read/reset, else hardware reset
module nor_flash_host import nor_host_pkg::*; #(
    parameter int ADDR_W = 26,
    parameter int HWRST_CYC = `NS_TO_CYC(`T_HWRST_NS)
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_cmd_valid,
    input wire op_e i_cmd_op,
    input wire logic [ADDR_W-1:0] i_cmd_addr,
    input wire logic [`PAGE_BITS-1:0] i_cmd_count,
    input wire logic i_word_valid,
    input wire logic [15:0] i_word_data,
    input wire logic [15:0] i_dq,
    input wire logic i_ready_busy_n,
    output logic o_cmd_ready,
    output logic o_cmd_refused,
    output logic o_cmd_done,
    output logic o_rd_valid,
    output logic [15:0] o_rd_data,
    output logic o_word_ack,
    output logic o_ce_n,
    output logic o_oe_n,
    output logic o_we_n,
    output logic [ADDR_W-1:0] o_addr,
    output logic [15:0] o_dq,
    output logic o_dq_oe,
    output logic o_rst_n,
    output logic o_flash_busy,
    output mode_e o_mode,
    output logic o_bypass,
    output logic o_suspended,
    output logic o_abort_seen
);

    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_SEQ = 3'h1,
        S_LOAD = 3'h2,
        S_LWAIT = 3'h3,
        S_CONF = 3'h4,
        S_HWRST = 3'h5
    } state_e;

    typedef struct packed {
        state_e st;
        op_e op;
        logic [2:0] step;
        logic [ADDR_W-1:0] addr;
        logic [`PAGE_BITS-1:0] count;
        logic [`PAGE_BITS:0] widx;
        logic [15:0] hold_cnt;
        mode_e mode;
        logic bypass;
        logic suspended;
        logic abort;
        logic prog_last;
        logic rb1;
        logic rb2;
        logic busy;
        logic cmd_ready;
        logic refused;
        logic done;
        logic rd_valid;
        logic [15:0] rd_data;
        logic word_ack;
        logic rst_n;
        logic start;
        logic cyc_read;
        logic [ADDR_W-1:0] cyc_addr;
        logic [15:0] cyc_data;
    } host_s;

    // {last, enters load phase, address, data}
    typedef struct packed {
        logic last;
        logic load;
        logic [ADDR_W-1:0] adr;
        logic [15:0] dat;
    } cyc_s;

    host_s r, next_r;
    logic bus_done;
    logic [15:0] bus_rdata;

    localparam logic [15:0] HWRST_CNT = 16'(HWRST_CYC);

    function automatic cyc_s seq_cycle(op_e op, logic [2:0] step, logic byp, logic [ADDR_W-1:0] a,
                                       logic [`PAGE_BITS-1:0] n);
        cyc_s c;
        logic [2:0] k;
        c = '0;
        k = step;
        if (byp && op == OP_BUF_PROGRAM) begin
            k = step + 3'h2;
        end
        if (byp && op == OP_BLOCK_ERASE) begin
            k = (step == 3'h0) ? 3'h2 : 3'h5;
        end
        if (k == 3'h0 || k == 3'h3) begin
            c.adr = ADDR_W'(`ADR_UNLOCK1);
            c.dat = `D_UNLOCK1;
        end else if (k == 3'h1 || k == 3'h4) begin
            c.adr = ADDR_W'(`ADR_UNLOCK2);
            c.dat = `D_UNLOCK2;
        end
        unique case (op)
            OP_RESET: begin
                c = '{1'b1, 1'b0, ADDR_W'(`ADR_ANY), `D_RESET};
            end
            OP_RESET3: begin
                if (k == 3'h2) c = '{1'b1, 1'b0, ADDR_W'(`ADR_ANY), `D_RESET};
            end
            OP_CFI_ENTER: begin
                c = '{1'b1, 1'b0, ADDR_W'(`ADR_UNLOCK1), `D_CFI};
            end
            OP_ASEL_ENTER: begin
                if (k == 3'h2) c = '{1'b1, 1'b0, ADDR_W'(`ADR_UNLOCK1), `D_ASEL};
            end
            OP_BYPASS_ENTER: begin
                if (k == 3'h2) c = '{1'b1, 1'b0, ADDR_W'(`ADR_UNLOCK1), `D_BYPASS};
            end
            OP_BYPASS_EXIT: begin
                c = '{k == 3'h1, 1'b0, ADDR_W'(`ADR_ANY), k == 3'h1 ? `D_BYPASS_RST2 : `D_BYPASS_RST1};
            end
            OP_BLOCK_ERASE: begin
                if (k == 3'h2) c = '{1'b0, 1'b0, ADDR_W'(`ADR_UNLOCK1), `D_ERASE_SETUP};
                if (k == 3'h5) c = '{1'b1, 1'b0, a, `D_ERASE_CONFIRM};
            end
            OP_SUSPEND: begin
                c = '{1'b1, 1'b0, ADDR_W'(`ADR_ANY), `D_SUSPEND};
            end
            OP_RESUME: begin
                c = '{1'b1, 1'b0, ADDR_W'(`ADR_ANY), `D_RESUME};
            end
            OP_BLANK_CHECK: begin
                c = '{1'b1, 1'b0, ADDR_W'(`ADR_UNLOCK1), `D_BLANK};
            end
            OP_BUF_PROGRAM: begin
                if (k == 3'h2) c = '{1'b0, 1'b0, a, `D_BUF_LOAD};
                if (k == 3'h3) c = '{1'b0, 1'b1, a, 16'(n)};
            end
            default: begin
                c = '{1'b1, 1'b0, a, 16'h0000};
            end
        endcase
        return c;
    endfunction

    function automatic logic refuse(op_e op, host_s s, logic busy);
        logic busy_hard;
        busy_hard = busy && !s.suspended;
        unique case (op)
            OP_RESET, OP_RESET3: refuse = busy_hard;
            OP_CFI_ENTER: refuse = s.mode == MODE_CFI || s.bypass;
            OP_ASEL_ENTER: refuse = busy_hard || s.mode == MODE_CFI || s.bypass;
            OP_BYPASS_ENTER: refuse = s.bypass || s.mode != MODE_READ;
            OP_BYPASS_EXIT: refuse = !s.bypass;
            OP_SUSPEND: refuse = s.suspended;
            OP_RESUME: refuse = !s.suspended;
            OP_BLOCK_ERASE, OP_BLANK_CHECK, OP_BUF_PROGRAM: refuse = busy_hard || s.mode != MODE_READ;
            default: refuse = 1'b0;
        endcase
    endfunction

    always_comb begin
        cyc_s c;
        op_e op;
        c = '0;
        op = i_cmd_op;
        next_r = r;
        next_r.rb1 = i_ready_busy_n;
        next_r.rb2 = r.rb1;
        next_r.busy = !r.rb2;
        next_r.start = 1'b0;
        next_r.refused = 1'b0;
        next_r.done = 1'b0;
        next_r.rd_valid = 1'b0;
        next_r.word_ack = 1'b0;
        unique case (r.st)
            S_IDLE: begin
                if (i_cmd_valid && r.cmd_ready) begin
                    if (op == OP_RESET && r.abort) begin
                        op = OP_RESET3;
                    end
                    next_r.op = op;
                    next_r.addr = i_cmd_addr;
                    next_r.count = i_cmd_count;
                    next_r.widx = '0;
                    next_r.step = 3'h0;
                    if (op == OP_HW_RESET) begin
                        next_r.st = S_HWRST;
                        next_r.rst_n = 1'b0;
                        next_r.hold_cnt = HWRST_CNT;
                        next_r.cmd_ready = 1'b0;
                    end else if (refuse(op, r, !r.rb2)) begin
                        next_r.refused = 1'b1;
                    end else begin
                        c = seq_cycle(op, 3'h0, r.bypass, i_cmd_addr, i_cmd_count);
                        next_r.st = S_SEQ;
                        next_r.cmd_ready = 1'b0;
                        next_r.start = 1'b1;
                        next_r.cyc_read = op == OP_READ;
                        next_r.cyc_addr = c.adr;
                        next_r.cyc_data = c.dat;
                    end
                end
            end
            S_SEQ: begin
                if (bus_done) begin
                    c = seq_cycle(r.op, r.step, r.bypass, r.addr, r.count);
                    if (c.load) begin
                        next_r.st = S_LOAD;
                    end else if (c.last) begin
                        next_r.st = S_IDLE;
                        next_r.cmd_ready = 1'b1;
                        next_r.done = 1'b1;
                        unique case (r.op)
                            OP_READ: begin
                                next_r.rd_valid = 1'b1;
                                next_r.rd_data = bus_rdata;
                                // abort error only means something after a buffered program
                                if (r.prog_last && bus_rdata[`ABORT_BIT]) next_r.abort = 1'b1;
                            end
                            OP_RESET, OP_RESET3: begin
                                next_r.mode = MODE_READ;
                                next_r.abort = 1'b0;
                                next_r.prog_last = 1'b0;
                            end
                            OP_CFI_ENTER: next_r.mode = MODE_CFI;
                            OP_ASEL_ENTER: next_r.mode = MODE_ASEL;
                            OP_BYPASS_ENTER: next_r.bypass = 1'b1;
                            OP_BYPASS_EXIT: next_r.bypass = 1'b0;
                            OP_SUSPEND: next_r.suspended = 1'b1;
                            OP_RESUME: next_r.suspended = 1'b0;
                            default: next_r.prog_last = 1'b0;
                        endcase
                    end else begin
                        c = seq_cycle(r.op, r.step + 3'h1, r.bypass, r.addr, r.count);
                        next_r.step = r.step + 3'h1;
                        next_r.start = 1'b1;
                        next_r.cyc_read = 1'b0;
                        next_r.cyc_addr = c.adr;
                        next_r.cyc_data = c.dat;
                    end
                end
            end
            S_LOAD: begin
                if (r.widx == {1'b0, r.count} + 10'h001) begin
                    next_r.st = S_CONF;
                    next_r.start = 1'b1;
                    next_r.cyc_addr = r.addr;
                    next_r.cyc_data = `D_BUF_CONFIRM;
                end else if (i_word_valid) begin
                    next_r.st = S_LWAIT;
                    next_r.start = 1'b1;
                    next_r.word_ack = 1'b1;
                    next_r.cyc_addr = {r.addr[ADDR_W-1:`PAGE_BITS], r.widx[`PAGE_BITS-1:0]};
                    next_r.cyc_data = i_word_data;
                end
            end
            S_LWAIT: begin
                if (bus_done) begin
                    next_r.st = S_LOAD;
                    next_r.widx = r.widx + 10'h001;
                end
            end
            S_CONF: begin
                if (bus_done) begin
                    next_r.st = S_IDLE;
                    next_r.cmd_ready = 1'b1;
                    next_r.done = 1'b1;
                    next_r.prog_last = 1'b1;
                end
            end
            S_HWRST: begin
                if (r.hold_cnt == 16'h0001) begin
                    next_r.st = S_IDLE;
                    next_r.rst_n = 1'b1;
                    next_r.cmd_ready = 1'b1;
                    next_r.done = 1'b1;
                    next_r.mode = MODE_READ;
                    next_r.bypass = 1'b0;
                    next_r.suspended = 1'b0;
                    next_r.abort = 1'b0;
                    next_r.prog_last = 1'b0;
                end else begin
                    next_r.hold_cnt = r.hold_cnt - 16'h0001;
                end
            end
            default: begin
                next_r.st = S_IDLE;
                next_r.cmd_ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            r <= '0;
            r.st <= S_IDLE;
            r.mode <= MODE_READ;
            r.rst_n <= 1'b1;
            r.cmd_ready <= 1'b1;
            r.rb1 <= 1'b1;
            r.rb2 <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    nor_bus_cycle #(
        .ADDR_W(ADDR_W)
    ) u_bus (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_start(r.start),
        .i_read(r.cyc_read),
        .i_addr(r.cyc_addr),
        .i_data(r.cyc_data),
        .i_dq(i_dq),
        .o_done(bus_done),
        .o_rdata(bus_rdata),
        .o_ce_n(o_ce_n),
        .o_oe_n(o_oe_n),
        .o_we_n(o_we_n),
        .o_addr(o_addr),
        .o_dq(o_dq),
        .o_dq_oe(o_dq_oe)
    );

    assign o_cmd_ready = r.cmd_ready;
    assign o_cmd_refused = r.refused;
    assign o_cmd_done = r.done;
    assign o_rd_valid = r.rd_valid;
    assign o_rd_data = r.rd_data;
    assign o_word_ack = r.word_ack;
    assign o_rst_n = r.rst_n;
    assign o_flash_busy = r.busy;
    assign o_mode = r.mode;
    assign o_bypass = r.bypass;
    assign o_suspended = r.suspended;
    assign o_abort_seen = r.abort;

endmodule // nor_flash_host

//--- bench/nor_flash_host_props.sv
module nor_flash_host_props import nor_host_pkg::*; #(
    parameter int ADDR_W = 26,
    parameter int HWRST_CYC = 1000
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic o_cmd_refused,
    input wire logic o_ce_n,
    input wire logic o_we_n,
    input wire logic [15:0] o_dq,
    input wire logic o_rst_n,
    input wire mode_e o_mode,
    input wire logic o_bypass,
    input wire logic o_suspended,
    input wire logic o_abort_seen
);
    timeunit 1ns / 1ps;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    logic we_q, hw;
    logic [15:0] w1, w2;
    int lo;
    // last two written words, taken as the write strobe rises
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            we_q <= 1'b1;
            hw <= 1'b0;
            w1 <= '0;
            w2 <= '0;
            lo <= 0;
        end else begin
            we_q <= o_we_n;
            lo <= o_rst_n ? 0 : lo + 1;
            if (!o_rst_n) begin
                hw <= 1'b1;
            end else if (o_we_n && !we_q) begin
                hw <= 1'b0;
            end
            if (o_we_n && !we_q) begin
                w1 <= o_dq;
                w2 <= w1;
            end
        end
    end
    we_in_ce_a: assert property (!o_we_n |-> !o_ce_n) else $error("write strobe outside select");
    refuse_idle_a: assert property (o_cmd_refused |-> o_ce_n && o_we_n) else $error("refused but bus active");
    rst_len_a: assert property ($rose(o_rst_n) |-> lo == HWRST_CYC) else $error("reset pulse length");
    hw_mode_a: assert property ($rose(o_rst_n) |-> ##[0:4] (o_mode == MODE_READ && !o_bypass))
        else $error("mode after hardware reset");
    byp_keep_a: assert property ($fell(o_bypass) && !$past(i_reset) |-> hw || {w2, w1} == 32'h0090_0000)
        else $error("bypass left without its exit sequence");
    cfi_in_a: assert property (o_mode == MODE_CFI && $past(o_mode) != MODE_CFI |-> w1 == 16'h0098)
        else $error("cfi entered without 98");
    asel_in_a: assert property (o_mode == MODE_ASEL && $past(o_mode) != MODE_ASEL |-> {w2, w1} == 32'h0055_0090)
        else $error("auto select entered without sequence");
    exit_a: assert property (o_mode == MODE_READ && $past(o_mode) != MODE_READ && !$past(i_reset) |-> hw || w1 == 16'h00F0)
        else $error("mode left without F0");
    susp_a: assert property ($rose(o_suspended) |-> w1 == 16'h00B0) else $error("suspend without B0");
    abort3_a: assert property (o_we_n && !we_q && o_dq == 16'h00F0 && o_abort_seen |-> w1 == 16'h0055)
        else $error("single write reset after abort");
endmodule // nor_flash_host_props

//--- bench/nor_flash_model.sv
module nor_flash_model import nor_host_pkg::*; #(
    parameter logic [15:0] MAKER_CODE = 16'h00A1, // arbitrary value
    parameter logic [15:0] PART_CODE = 16'h0C3E, // arbitrary value
    parameter logic [9:0] PROT_BLK = 10'h001,
    parameter int ERASE_NS = 20000
) (
    input wire logic i_ce_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic i_rst_n,
    input wire logic [25:0] i_addr,
    input wire logic [15:0] i_dq,
    output logic [15:0] o_dq,
    output logic o_ready_busy_n
);
    timeunit 1ns / 1ps;
    mode_e mode = MODE_READ;
    logic byp = 0, es = 0, b90 = 0, busy = 0, susp = 0;
    logic [1:0] st = 0;
    logic [15:0] rd, last = 0;
    time erase_end = 0;
    always @(negedge i_rst_n or posedge i_we_n) begin
        if (!i_rst_n) begin
            mode = MODE_READ;
            {byp, es, b90, busy, susp, st} = '0;
        end else if (!i_ce_n) begin
            wr(i_addr[10:0], i_dq[7:0]);
        end
    end
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        logic hold;
        hold = busy && !susp;
        if (st == 1 && a == 11'h2AA && d == 8'h55) st = 2;
        else if (d == 8'hAA && a == 11'h555) st = 1;
        else begin
            if (b90 && d == 8'h00) byp = 0;
            else if (d == 8'hF0 && !hold) mode = MODE_READ;
            else if (d == 8'h98 && mode != MODE_CFI) mode = MODE_CFI;
            else if (d == 8'h90 && st == 2 && !hold) mode = MODE_ASEL;
            else if (d == 8'h20 && st == 2) byp = 1;
            else if (d == 8'hB0 && busy) susp = 1;
            else if (d == 8'h30 && es && (st == 2 || byp)) begin
                busy = 1;
                erase_end = $time + ERASE_NS;
            end else if (d == 8'h30 && susp) susp = 0;
            // anything else abandons a half-built sequence
            es = d == 8'h80 && (st == 2 || byp);
            b90 = d == 8'h90 && byp;
            st = 0;
        end
    endtask
    always #100 if (busy && !susp && $time >= erase_end) busy = 0;
    always @* begin
        case (mode)
            MODE_CFI: rd = {8'hC0, i_addr[7:0]};
            MODE_ASEL: begin
                if (i_addr[15:0] == 16'h0002) rd = {15'h0, i_addr[25:16] == PROT_BLK};
                else if (i_addr == 26'h3) rd = 16'h0009;
                else if (i_addr == 26'h0) rd = MAKER_CODE;
                else rd = PART_CODE;
            end
            default: rd = i_addr[15:0];
        endcase
    end
    // released bus shows the inverse of the last word, not a held value
    always @(posedge i_oe_n) last = rd;
    assign o_dq = (!i_ce_n && !i_oe_n) ? rd : ~last;
    assign o_ready_busy_n = !(busy && !susp);
endmodule // nor_flash_model

//--- bench/test_nor_flash_host.sv
module test_nor_flash_host import nor_host_pkg::*;;
    timeunit 1ns / 1ps;
    logic i_clk = 0, i_reset = 1, i_cmd_valid = 0, i_word_valid = 0;
    op_e i_cmd_op = OP_READ;
    logic [25:0] i_cmd_addr = '0, o_addr;
    logic [8:0] i_cmd_count = '0;
    logic [15:0] i_word_data = 16'hA500, o_rd_data, o_dq;
    wire [15:0] i_dq;
    wire i_ready_busy_n;
    logic o_cmd_ready, o_cmd_refused, o_cmd_done, o_rd_valid, o_word_ack, o_ce_n, o_oe_n, o_we_n;
    logic o_dq_oe, o_rst_n, o_flash_busy, o_bypass, o_suspended, o_abort_seen;
    mode_e o_mode;
    int err_count = 0, cmp_count = 0, cyc = 0;
    logic [41:0] wq[$];
    always #5 i_clk = ~i_clk;
    nor_flash_host #(.HWRST_CYC(20)) dut_u (.*);
    nor_flash_model flash_u (.i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_rst_n(o_rst_n),
        .i_addr(o_addr), .i_dq(o_dq), .o_dq(i_dq), .o_ready_busy_n(i_ready_busy_n));
    always @(posedge o_we_n) if (!o_ce_n) wq.push_back({o_addr, o_dq_oe && o_oe_n ? o_dq : ~o_dq});
    always @(posedge i_clk) if (o_word_ack) i_word_data <= i_word_data + 16'h0001;
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            results();
        end
    end
    task automatic chk(input string s, input logic [41:0] e, input logic [41:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %0h seen %0h", s, e, g);
        end
    endtask
    task automatic w(input logic [25:0] a, input logic [15:0] d);
        chk("bus write", {a, d}, wq.size() ? wq.pop_front() : '1);
    endtask
    task automatic unl;
        w(26'h555, 16'h00AA);
        w(26'h2AA, 16'h0055);
    endtask
    task automatic cmd(input op_e op, input logic [25:0] a, input logic rf, input logic [8:0] n = 0);
        int k;
        @(posedge i_clk);
        wq.delete();
        i_cmd_valid <= 1;
        i_cmd_op <= op;
        i_cmd_addr <= a;
        i_cmd_count <= n;
        @(posedge i_clk);
        i_cmd_valid <= 0;
        #1;
        for (k = 0; k < 3000 && !(o_cmd_done || o_cmd_refused); k++) @(posedge i_clk) #1;
        chk("answer", {rf, !rf, !rf && op == OP_READ}, {o_cmd_refused, o_cmd_done, o_rd_valid});
    endtask
    task automatic t_asel;
        cmd(OP_ASEL_ENTER, 0, 0);
        unl();
        w(26'h555, 16'h0090);
        chk("mode", MODE_ASEL, o_mode);
        cmd(OP_READ, 0, 0);
        chk("maker", 16'h00A1, o_rd_data);
        cmd(OP_READ, 26'h0010002, 0);
        chk("protected", 16'h0001, o_rd_data);
        cmd(OP_READ, 26'h0020002, 0);
        chk("open", 16'h0000, o_rd_data);
        cmd(OP_READ, 26'h3, 0);
        chk("ext block", 16'h0009, o_rd_data);
        cmd(OP_RESET, 0, 0);
        w(0, 16'h00F0);
        chk("mode", MODE_READ, o_mode);
    endtask
    task automatic t_cfi;
        cmd(OP_CFI_ENTER, 0, 0);
        w(26'h555, 16'h0098);
        cmd(OP_READ, 26'h10, 0);
        chk("cfi data", 16'hC010, o_rd_data);
        cmd(OP_CFI_ENTER, 0, 1);
        cmd(OP_RESET, 0, 0);
        chk("mode", MODE_READ, o_mode);
    endtask
    task automatic t_erase(input logic byp);
        int k;
        cmd(OP_BLOCK_ERASE, 26'h0020000, 0);
        if (!byp) begin
            unl();
            w(26'h555, 16'h0080);
            unl();
        end else w(26'h555, 16'h0080);
        w(26'h0020000, 16'h0030);
        for (k = 0; k < 10 && !o_flash_busy; k++) @(posedge i_clk);
        chk("busy", 1, o_flash_busy);
        cmd(OP_RESET, 0, 1);
        cmd(OP_ASEL_ENTER, 0, 1);
        cmd(OP_SUSPEND, 0, 0);
        w(0, 16'h00B0);
        if (!byp) begin
            cmd(OP_ASEL_ENTER, 0, 0);
            cmd(OP_RESET, 0, 0);
            chk("suspend kept", {1'b1, MODE_READ}, {o_suspended, o_mode});
        end
        cmd(OP_RESUME, 0, 0);
        w(0, 16'h0030);
        for (k = 0; k < 3000 && o_flash_busy; k++) @(posedge i_clk);
        chk("erase over", 0, o_flash_busy);
        cmd(OP_BLANK_CHECK, 0, 0);
        w(26'h555, 16'h0033);
    endtask
    task automatic t_byp;
        cmd(OP_BYPASS_ENTER, 0, 0);
        unl();
        w(26'h555, 16'h0020);
        cmd(OP_RESET, 0, 0);
        chk("bypass", 1, o_bypass);
        t_erase(1);
        cmd(OP_BYPASS_EXIT, 0, 0);
        w(0, 16'h0090);
        w(0, 16'h0000);
        chk("bypass", 0, o_bypass);
    endtask
    task automatic t_buf;
        @(posedge i_clk);
        i_word_valid <= 1;
        cmd(OP_BUF_PROGRAM, 26'h0040207, 0, 9'd1);
        unl();
        w(26'h0040207, 16'h0025);
        w(26'h0040207, 16'h0001);
        w(26'h0040200, 16'hA500);
        w(26'h0040201, 16'hA501);
        w(26'h0040207, 16'h0029);
        cmd(OP_READ, 26'h2, 0);
        chk("abort", 1, o_abort_seen);
        cmd(OP_RESET, 0, 0);
        unl();
        w(0, 16'h00F0);
        chk("abort", 0, o_abort_seen);
    endtask
    task automatic results;
        $display("errors %0d checks %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge i_clk);
        i_reset <= 0;
        #1;
        chk("reset", {2'b11, MODE_READ}, {o_cmd_ready, o_ce_n, o_mode});
        t_asel();
        t_cfi();
        t_erase(0);
        t_byp();
        t_buf();
        cmd(OP_CFI_ENTER, 0, 0);
        cmd(OP_HW_RESET, 0, 0);
        chk("hw reset", {1'b1, MODE_READ}, {o_rst_n, o_mode});
        results();
    end
endmodule // test_nor_flash_host
bind nor_flash_host nor_flash_host_props #(.ADDR_W(ADDR_W), .HWRST_CYC(HWRST_CYC)) props_u (.*);
